// File: idle_timer.sv
`include "qs_defs.svh"
`default_nettype none
module idle_timer
	import qs_pkg::*;
#(
	parameter int unsigned CYCLES = `QS_TIMEOUT_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic kick,
	output logic expire
);
	localparam logic [31:0] TOP = 32'(CYCLES - 1);
	tmr_state_s s;
	tmr_state_s n;

	// Any key, or leaving the menu, restarts the count
	always_comb begin
		n = s;
		n.expire = 1'b0;
		if (kick || !run) begin
			n.cnt = '0;
		end else if (s.cnt == TOP) begin
			n.cnt = '0;
			n.expire = 1'b1;
		end else begin
			n.cnt = s.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign expire = s.expire;

	a_timer_top: assert property (@(posedge mclk) disable iff (rst) $rose(s.expire) |-> $past(s.cnt) == TOP)
		else $error("idle expiry before full count");
endmodule : idle_timer
`default_nettype wire

// File: io_map.sv
`include "qs_defs.svh"
`default_nettype none
module io_map
	import qs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [3:0] cmd_type,
	input wire logic limit_off,
	input wire logic fault_open,
	input wire logic [6:0] din_pins,
	input wire drv_status_s status,
	output io_func_s din_func,
	output logic [4:0] dout_pins
);
	io_state_s s;
	io_state_s n;
	logic pulse;

	// Pulse types own inputs 1 to 3; host control frees them
	assign pulse = cmd_type <= `QS_CMD_AB;

	always_comb begin
		n = s;
		n.d1 = din_pins;
		n.d2 = s.d1;
		n.func.enable = pulse & s.d2[0];
		n.func.fault_reset = pulse & s.d2[1];
		n.func.home_start = pulse & s.d2[2];
		n.func.limit_pos = ~limit_off & s.d2[3];
		n.func.limit_neg = ~limit_off & s.d2[4];
		n.func.home_sensor = s.d2[6];
		// Input 6 carries no default function
		n.dout[0] = status.ready;
		n.dout[1] = status.brake;
		n.dout[2] = status.pos_reached;
		n.dout[3] = status.zero_speed;
		n.dout[4] = fault_open ? status.fault : ~status.fault;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign din_func = s.func;
	assign dout_pins = s.dout;

	a_limit_off: assert property (@(posedge mclk) disable iff (rst) ce && limit_off |=> !s.func.limit_pos)
		else $error("limit active while disabled");
	a_fault_pol: assert property (@(posedge mclk) disable iff (rst)
		ce |=> s.dout[4] == ($past(fault_open) ~^ $past(status.fault)))
		else $error("fault output polarity wrong");
	a_host_free: assert property (@(posedge mclk) disable iff (rst) ce && !pulse |=> !s.func.enable)
		else $error("enable input mapped in host mode");
endmodule : io_map
`default_nettype wire

// File: keypad_model.sv
`default_nettype none
// ----------------------------------------
// Panel keys and input wiring
// ----------------------------------------
module keypad_model (
	input wire logic mclk,
	output logic [4:0] keys,
	output logic [6:0] din_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// Connector unplugged at time zero, inputs idle low
	initial begin
		keys = 5'h00;
		din_pins = 7'h00;
	end
	// Held long enough to pass the two-stage synchroniser
	task automatic press(input int k);
		keys[k] <= 1'b1;
		repeat (4) @(posedge mclk);
		keys[k] <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : press
	task automatic set_din(input logic [6:0] v);
		din_pins <= v;
	endtask : set_din
endmodule : keypad_model
`default_nettype wire

// File: qs_defs.svh
`ifndef QS_DEFS_SVH
`define QS_DEFS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define QS_CLK_HZ 50_000_000
`define QS_TIMEOUT_S 30
`define QS_TIMEOUT_CYCLES (`QS_TIMEOUT_S * `QS_CLK_HZ)
// ----------------------------------------
// APB map
// ----------------------------------------
`define QS_OFS_STATUS 8'h00
`define QS_OFS_CTRL 8'h04
`define QS_OFS_STIFF 8'h08
`define QS_REG_ACT 3'h2
`define QS_REG_SAVED 3'h3
`define QS_ST_MENU 0
`define QS_ST_REJECT 1
`define QS_ST_UNKNOWN 2
`define QS_ST_MISMATCH 3
`define QS_ST_ENABLED 4
`define QS_ST_IDX 5
`define QS_ST_STATE 8
`define QS_CTRL_LOCK 0
// ----------------------------------------
// Parameter slots
// ----------------------------------------
`define QS_NUM_PARAMS 7
`define QS_IDX_SAVE 3'h0
`define QS_IDX_MODEL 3'h1
`define QS_IDX_CMD 3'h2
`define QS_IDX_NUM 3'h3
`define QS_IDX_DEN 3'h4
`define QS_IDX_PACK 3'h5
`define QS_IDX_HOME 3'h6
`define QS_IDX_LAST 3'h6
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define QS_RST_SAVE 16'h0000
`define QS_RST_MODEL 16'h0000
`define QS_RST_CMD 16'h0001
`define QS_RST_GEAR 16'h03e8
`define QS_RST_PACK 16'h1001
`define QS_RST_HOME 16'h0000
`define QS_RST_STIFF 5'h0a
`define QS_STIFF_SCREW 5'h0d
`define QS_CMD_AB 4'h2
`define QS_CMD_HOST 4'h8
`define QS_MODE_PULSE 8'hfc
`define QS_SAVE_STORE 16'h0001
`define QS_SAVE_BOOT 16'h0002
`define QS_BOOT_ONLY 16'h0003
`define QS_SAVE_INIT 16'h000a
`define QS_LOAD_SCREW 4'h2
`define QS_DIGIT_MAX2 4'h2
`define QS_DIGIT_MAX1 4'h1
`define QS_DEC_LIMIT 16'h270f
`define QS_ALL_F 16'hffff
`define QS_PACK_LIMIT_BIT 8
`define QS_PACK_POL_BIT 12
// ----------------------------------------
// Keys
// ----------------------------------------
`define QS_NUM_KEYS 5
`define QS_KEY_MENU 0
`define QS_KEY_NEXT 1
`define QS_KEY_UP 2
`define QS_KEY_DOWN 3
`define QS_KEY_SET 4
`endif

// File: qs_pkg.sv
`include "qs_defs.svh"
`default_nettype none
package qs_pkg;
	typedef enum logic [1:0] {st_idle = 2'h0, st_browse = 2'h1, st_edit = 2'h3} menu_st_e;
	typedef logic [15:0] val_t;
	typedef struct packed {
		logic home_sensor;
		logic limit_neg;
		logic limit_pos;
		logic home_start;
		logic fault_reset;
		logic enable;
	} io_func_s;
	typedef struct packed {
		logic fault;
		logic zero_speed;
		logic pos_reached;
		logic brake;
		logic ready;
	} drv_status_s;
	typedef struct packed {
		logic [6:0] d1;
		logic [6:0] d2;
		io_func_s func;
		logic [4:0] dout;
	} io_state_s;
	typedef struct packed {
		logic [31:0] cnt;
		logic expire;
	} tmr_state_s;
	typedef struct packed {
		menu_st_e st;
		logic [2:0] idx;
		val_t edit;
		val_t [`QS_NUM_PARAMS-1:0] act;
		val_t [`QS_NUM_PARAMS-1:0] saved;
		logic reject;
		logic mismatch;
		logic key_lock;
		logic [`QS_NUM_KEYS-1:0] k1;
		logic [`QS_NUM_KEYS-1:0] k2;
		logic [`QS_NUM_KEYS-1:0] kp;
		logic [4:0] stiff;
		logic recompute;
		logic reboot;
		logic [7:0] wmode;
		logic gear_en;
		val_t disp;
		logic disp_hex;
		logic disp_flash;
		logic [31:0] prdata;
	} menu_state_s;
endpackage : qs_pkg
`default_nettype wire

// File: quick_setup_parameter_menu.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`include "qs_defs.svh"
`default_nettype none
module quick_setup_parameter_menu
	import qs_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = `QS_TIMEOUT_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`QS_NUM_KEYS-1:0] keys,
	input wire logic drive_enabled,
	input wire logic attached_valid,
	input wire logic [15:0] attached_model,
	input wire logic inertia_done,
	input wire logic [4:0] inertia_stiffness,
	input wire logic [7:0] comm_work_mode,
	input wire logic [6:0] din_pins,
	input wire drv_status_s drv_status,
	output io_func_s din_func,
	output logic [4:0] dout_pins,
	output logic [15:0] disp_digits,
	output logic disp_hex,
	output logic disp_flash,
	output logic reject_ind,
	output logic mismatch_fault,
	output logic menu_active,
	output logic [7:0] work_mode,
	output logic gear_enable,
	output logic [15:0] gear_numerator,
	output logic [15:0] gear_denominator,
	output logic [3:0] load_type,
	output logic [3:0] application,
	output logic [4:0] stiffness_level,
	output logic loop_recompute,
	output logic reboot_req
);
	// ----------------------------------------
	// Constants and helpers
	// ----------------------------------------
	localparam val_t [`QS_NUM_PARAMS-1:0] DEF_ACT = {`QS_RST_HOME, `QS_RST_PACK, `QS_RST_GEAR,
		`QS_RST_GEAR, `QS_RST_CMD, `QS_RST_MODEL, `QS_RST_SAVE};
	localparam menu_state_s RST_STATE = '{st: st_idle, act: DEF_ACT, saved: DEF_ACT,
		stiff: `QS_RST_STIFF, wmode: `QS_MODE_PULSE, gear_en: 1'b1, default: '0};

	// Permitted values per slot; motor and homing take any code
	function automatic logic in_range(input logic [2:0] i, input val_t v);
		case (i)
			`QS_IDX_SAVE: return v == `QS_SAVE_STORE || v == `QS_SAVE_BOOT ||
				v == `QS_BOOT_ONLY || v == `QS_SAVE_INIT;
			`QS_IDX_CMD: return v[15:4] == 12'h000 && (v[3:0] <= `QS_CMD_AB || v[3:0] == `QS_CMD_HOST);
			`QS_IDX_NUM, `QS_IDX_DEN: return v != 16'h0000;
			`QS_IDX_PACK: return v[15:12] <= `QS_DIGIT_MAX1 && v[11:8] <= `QS_DIGIT_MAX1 &&
				v[7:4] <= `QS_DIGIT_MAX2 && v[3:0] <= `QS_DIGIT_MAX2;
			default: return 1'b1;
		endcase
	endfunction : in_range

	// Binary to four BCD digits by shift-and-add-three
	function automatic val_t to_bcd(input logic [13:0] b);
		logic [29:0] sh;
		sh = {16'h0000, b};
		for (int k = 0; k < 14; k++) begin
			for (int d = 0; d < 4; d++) begin
				if (sh[14 + 4 * d +: 4] >= 4'h5) begin
					sh[14 + 4 * d +: 4] = sh[14 + 4 * d +: 4] + 4'h3;
				end
			end
			sh = {sh[28:0], 1'b0};
		end
		return sh[29:14];
	endfunction : to_bcd

	// Wide slots follow the decimal/hex display rule
	function automatic logic numeric_slot(input logic [2:0] i);
		return i == `QS_IDX_NUM || i == `QS_IDX_DEN || i == `QS_IDX_HOME;
	endfunction : numeric_slot

	// ----------------------------------------
	// State and events
	// ----------------------------------------
	menu_state_s s;
	menu_state_s n;
	logic [`QS_NUM_KEYS-1:0] press;
	logic set_try;
	logic blocked;
	logic accept;
	logic save_go;
	logic expire;
	logic apb_setup;
	logic apb_wr;
	logic addr_ok;

	// Key edges come from the second sync stage only
	assign press = s.k2 & ~s.kp & {`QS_NUM_KEYS{~s.key_lock}};
	assign set_try = s.st == st_edit && press[`QS_KEY_SET];
	// Enabled drive or bad value: refuse, keep both copies
	assign blocked = set_try && (drive_enabled || !in_range(s.idx, s.edit));
	assign accept = set_try && !blocked;
	assign save_go = accept && s.idx == `QS_IDX_SAVE;

	// APB decode; zero wait states
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign addr_ok = paddr == `QS_OFS_STATUS || paddr == `QS_OFS_CTRL || paddr == `QS_OFS_STIFF ||
		((paddr[7:5] == `QS_REG_ACT || paddr[7:5] == `QS_REG_SAVED) &&
		paddr[4:2] <= `QS_IDX_LAST && paddr[1:0] == 2'h0);

	idle_timer #(
		.CYCLES(TIMEOUT_CYCLES)
	) u_idle_timer (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.run(s.st != st_idle),
		.kick(|press),
		.expire(expire)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		val_t shown;
		shown = (s.st == st_edit) ? s.edit : s.act[s.idx];
		n = s;
		n.k1 = keys;
		n.k2 = s.k1;
		n.kp = s.k2;
		n.recompute = 1'b0;
		n.reboot = 1'b0;

		// Menu walk: browse slots, edit one, confirm or back out
		case (s.st)
			st_idle: begin
				if (press[`QS_KEY_MENU]) begin
					n.st = st_browse;
					n.idx = `QS_IDX_SAVE;
				end
			end
			st_browse: begin
				if (press[`QS_KEY_MENU]) begin
					n.st = st_idle;
				end else if (press[`QS_KEY_NEXT]) begin
					n.idx = (s.idx == `QS_IDX_LAST) ? `QS_IDX_SAVE : s.idx + 3'h1;
				end else if (press[`QS_KEY_SET]) begin
					n.st = st_edit;
					n.edit = s.act[s.idx];
				end
			end
			st_edit: begin
				if (press[`QS_KEY_MENU] || press[`QS_KEY_SET]) begin
					n.st = st_browse;
				end else if (press[`QS_KEY_UP]) begin
					n.edit = s.edit + 16'h0001;
				end else if (press[`QS_KEY_DOWN]) begin
					n.edit = s.edit - 16'h0001;
				end
			end
			default: begin
				n.st = st_idle;
			end
		endcase
		// Idle timeout forces re-entry from the top
		if (expire) begin
			n.st = st_idle;
		end

		// Confirmed value is live at once; saved copy changes only on a store from the save slot or when a blank motor model is learned
		if (accept) begin
			n.act[s.idx] = s.edit;
		end
		if (save_go) begin
			case (s.edit)
				`QS_SAVE_STORE, `QS_SAVE_BOOT: begin
					n.saved = s.act;
					n.recompute = 1'b1;
					n.stiff = (s.act[`QS_IDX_PACK][3:0] == `QS_LOAD_SCREW) ? `QS_STIFF_SCREW : `QS_RST_STIFF;
					n.reboot = s.edit == `QS_SAVE_BOOT;
				end
				`QS_BOOT_ONLY: begin
					n.reboot = 1'b1;
				end
				`QS_SAVE_INIT: begin
					for (int i = 2; i < `QS_NUM_PARAMS; i++) begin
						n.act[i] = DEF_ACT[i];
					end
				end
				default: begin
				end
			endcase
		end

		// Motor identity: learn when blank, else compare
		if (attached_valid) begin
			if (s.saved[`QS_IDX_MODEL] == `QS_RST_MODEL) begin
				if (attached_model != `QS_RST_MODEL) begin
					n.act[`QS_IDX_MODEL] = attached_model;
					n.saved[`QS_IDX_MODEL] = attached_model;
				end
			end else begin
				n.mismatch = attached_model != s.saved[`QS_IDX_MODEL];
			end
		end

		// A fresh inertia result overrides the load default
		if (inertia_done) begin
			n.stiff = inertia_stiffness;
		end

		// Software side: lock keys, clear refusal flag
		if (apb_wr && paddr == `QS_OFS_CTRL) begin
			n.key_lock = pwdata[`QS_CTRL_LOCK];
		end
		if (apb_wr && paddr == `QS_OFS_STATUS && pwdata[`QS_ST_REJECT]) begin
			n.reject = 1'b0;
		end
		// Set after clear so a refusal in the clear cycle survives
		if (blocked) begin
			n.reject = 1'b1;
		end

		// Mode and gear follow the live command type digit
		n.gear_en = n.act[`QS_IDX_CMD][3:0] <= `QS_CMD_AB;
		n.wmode = n.gear_en ? `QS_MODE_PULSE : comm_work_mode;

		// Display: fault flash first, then slot value
		n.disp_hex = 1'b0;
		n.disp_flash = 1'b0;
		if (s.act[`QS_IDX_MODEL] == `QS_RST_MODEL || s.mismatch) begin
			n.disp = `QS_ALL_F;
			n.disp_flash = 1'b1;
		end else if (s.st == st_idle) begin
			n.disp = 16'h0000;
		end else if (numeric_slot(s.idx) && shown > `QS_DEC_LIMIT) begin
			n.disp = shown;
			n.disp_hex = 1'b1;
		end else if (numeric_slot(s.idx)) begin
			n.disp = to_bcd(shown[13:0]);
		end else begin
			n.disp = shown;
		end

		// Read data captured in the setup phase
		if (apb_setup) begin
			n.prdata = 32'h0000_0000;
			if (paddr == `QS_OFS_STATUS) begin
				n.prdata[`QS_ST_MENU] = s.st != st_idle;
				n.prdata[`QS_ST_REJECT] = s.reject;
				n.prdata[`QS_ST_UNKNOWN] = s.act[`QS_IDX_MODEL] == `QS_RST_MODEL;
				n.prdata[`QS_ST_MISMATCH] = s.mismatch;
				n.prdata[`QS_ST_ENABLED] = drive_enabled;
				n.prdata[`QS_ST_IDX +: 3] = s.idx;
				n.prdata[`QS_ST_STATE +: 2] = s.st;
			end else if (paddr == `QS_OFS_CTRL) begin
				n.prdata[`QS_CTRL_LOCK] = s.key_lock;
			end else if (paddr == `QS_OFS_STIFF) begin
				n.prdata[4:0] = s.stiff;
			end else if (addr_ok && paddr[7:5] == `QS_REG_ACT) begin
				n.prdata[15:0] = s.act[paddr[4:2]];
			end else if (addr_ok) begin
				n.prdata[15:0] = s.saved[paddr[4:2]];
			end
		end
	end

	// Synchronous reset wins over the clock enable
	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= RST_STATE;
		end else if (ce) begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = s.prdata;
	assign disp_digits = s.disp;
	assign disp_hex = s.disp_hex;
	assign disp_flash = s.disp_flash;
	assign reject_ind = s.reject;
	assign mismatch_fault = s.mismatch;
	assign menu_active = s.st != st_idle;
	assign work_mode = s.wmode;
	assign gear_enable = s.gear_en;
	assign gear_numerator = s.act[`QS_IDX_NUM];
	assign gear_denominator = s.act[`QS_IDX_DEN];
	assign load_type = s.act[`QS_IDX_PACK][3:0];
	assign application = s.act[`QS_IDX_PACK][7:4];
	assign stiffness_level = s.stiff;
	assign loop_recompute = s.recompute;
	assign reboot_req = s.reboot;

	io_map u_io_map (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.cmd_type(s.act[`QS_IDX_CMD][3:0]),
		.limit_off(s.act[`QS_IDX_PACK][`QS_PACK_LIMIT_BIT]),
		.fault_open(s.act[`QS_IDX_PACK][`QS_PACK_POL_BIT]),
		.din_pins(din_pins),
		.status(drv_status),
		.din_func(din_func),
		.dout_pins(dout_pins)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_set_bad;
		ce && set_try && !drive_enabled && !in_range(s.idx, s.edit) && !attached_valid;
	endsequence
	sequence s_set_enabled;
		ce && set_try && drive_enabled && !attached_valid;
	endsequence
	sequence s_blank_seen;
		ce && attached_valid && s.saved[`QS_IDX_MODEL] == `QS_RST_MODEL && attached_model != `QS_RST_MODEL;
	endsequence
	sequence s_other_motor;
		ce && attached_valid && s.saved[`QS_IDX_MODEL] != `QS_RST_MODEL &&
			attached_model != s.saved[`QS_IDX_MODEL];
	endsequence
	sequence s_store;
		ce && save_go && s.edit == `QS_SAVE_STORE && !attached_valid && !inertia_done;
	endsequence

	a_range_reject: assert property (@(posedge mclk) disable iff (rst) s_set_bad |=> s.reject ##0 $stable(s.act))
		else $error("out-of-range value taken");
	a_enable_reject: assert property (@(posedge mclk) disable iff (rst)
		s_set_enabled |=> s.reject && $stable(s.act) && $stable(s.saved))
		else $error("edit taken while enabled");
	a_timeout_exit: assert property (@(posedge mclk) disable iff (rst) ce && expire |=> s.st == st_idle)
		else $error("menu kept after timeout");
	a_saved_hold: assert property (@(posedge mclk) disable iff (rst)
		ce && !save_go && !attached_valid |=> $stable(s.saved))
		else $error("saved copy changed without save");
	a_model_learn: assert property (@(posedge mclk) disable iff (rst)
		s_blank_seen |=> s.saved[`QS_IDX_MODEL] == $past(attached_model))
		else $error("blank model not learned");
	a_mismatch_flash: assert property (@(posedge mclk) disable iff (rst)
		s_other_motor |=> s.mismatch ##1 (!$past(ce) || (s.disp == `QS_ALL_F && s.disp_flash)))
		else $error("motor mismatch not flagged");
	a_pulse_mode: assert property (@(posedge mclk) disable iff (rst)
		s.act[`QS_IDX_CMD][3:0] <= `QS_CMD_AB |-> s.wmode == `QS_MODE_PULSE && s.gear_en)
		else $error("pulse type without mode minus four");
	a_save_recompute: assert property (@(posedge mclk) disable iff (rst)
		s_store |=> s.recompute && s.saved == $past(s.act) ##1 !s.recompute)
		else $error("save did not store and recompute");
	a_stiff_update: assert property (@(posedge mclk) disable iff (rst)
		ce && inertia_done |=> s.stiff == $past(inertia_stiffness))
		else $error("stiffness not updated");
endmodule : quick_setup_parameter_menu
`default_nettype wire

// File: quick_setup_parameter_menu_bench.sv
`default_nettype none
module quick_setup_parameter_menu_bench
	import qs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, drive_enabled, attached_valid, inertia_done;
	logic [7:0] paddr, comm_work_mode, work_mode;
	logic [31:0] pwdata, prdata;
	logic [4:0] keys, inertia_stiffness, dout_pins, stiffness_level;
	logic [15:0] attached_model, disp_digits, gear_numerator;
	logic [6:0] din_pins;
	logic [3:0] load_type;
	drv_status_s drv_status;
	io_func_s din_func;
	logic disp_flash, reject_ind, mismatch_fault, menu_active, gear_enable, disp_hex, ce;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// ----------------------------------------
	// Clock, time-zero values, hang guard
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{psel, penable, pwrite, drive_enabled, attached_valid, inertia_done} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		comm_work_mode = 8'h03;
		attached_model = 16'h0000;
		inertia_stiffness = 5'h00;
		drv_status = 5'h01;
	end
	// Whole run needs a few thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	keypad_model keypad_model_i (.mclk(mclk), .keys(keys), .din_pins(din_pins));
	// Short idle limit keeps the timeout test brief
	quick_setup_parameter_menu #(.TIMEOUT_CYCLES(40)) quick_setup_parameter_menu_i (
		.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.keys(keys), .drive_enabled(drive_enabled), .attached_valid(attached_valid),
		.attached_model(attached_model), .inertia_done(inertia_done), .inertia_stiffness(inertia_stiffness),
		.comm_work_mode(comm_work_mode), .din_pins(din_pins), .drv_status(drv_status), .din_func(din_func),
		.dout_pins(dout_pins), .disp_digits(disp_digits), .disp_hex(disp_hex), .disp_flash(disp_flash),
		.reject_ind(reject_ind),
		.mismatch_fault(mismatch_fault), .menu_active(menu_active), .work_mode(work_mode),
		.gear_enable(gear_enable), .gear_numerator(gear_numerator), .gear_denominator(),
		.load_type(load_type), .application(),
		.stiffness_level(stiffness_level), .loop_recompute(), .reboot_req());
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v,
		output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the slave
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never drives psel twice in one step
		@(posedge mclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic e;
		apb(1'b0, a, 32'h0000_0000, v, e);
		chk(v, exp);
	endtask : rd
	// Waits out the idle limit so every edit starts from idle
	task automatic edit(input int idx, input int ups, input int downs);
		repeat (60) @(posedge mclk);
		keypad_model_i.press(0);
		repeat (idx) keypad_model_i.press(1);
		keypad_model_i.press(4);
		repeat (ups) keypad_model_i.press(2);
		repeat (downs) keypad_model_i.press(3);
		keypad_model_i.press(4);
		repeat (4) @(posedge mclk);
	endtask : edit
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		logic e;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(8'h48, 32'h0000_0001);
		rd(8'h4c, 32'h0000_03e8);
		rd(8'h50, 32'h0000_03e8);
		rd(8'h54, 32'h0000_1001);
		chk(gear_enable, 1'b1);
		chk(gear_numerator, 16'h03e8);
		chk(disp_flash, 1'b1);
		$display("reset values done");
		edit(2, 0, 1);
		rd(8'h48, 32'h0000_0000);
		rd(8'h68, 32'h0000_0001);
		chk(work_mode, 8'hfc);
		chk(menu_active, 1'b1);
		repeat (50) @(posedge mclk);
		chk(menu_active, 1'b0);
		$display("command type and timeout done");
		edit(2, 0, 1);
		chk(reject_ind, 1'b1);
		rd(8'h48, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_0002, v, e);
		rd(8'h00, 32'h0000_0145);
		drive_enabled <= 1'b1;
		edit(2, 1, 0);
		chk(reject_ind, 1'b1);
		rd(8'h48, 32'h0000_0000);
		drive_enabled <= 1'b0;
		$display("refusals done");
		edit(2, 8, 0);
		rd(8'h48, 32'h0000_0008);
		keypad_model_i.set_din(7'h7f);
		repeat (6) @(posedge mclk);
		chk(work_mode, 8'h03);
		chk(din_func, 6'h38);
		chk(dout_pins, 5'h01);
		drv_status <= 5'h10;
		repeat (3) @(posedge mclk);
		chk(dout_pins, 5'h10);
		// Packed field 1101: limit switches off, load type belt
		edit(5, 256, 0);
		chk(din_func, 6'h20);
		chk(load_type, 4'h1);
		keypad_model_i.set_din(7'h00);
		edit(0, 1, 0);
		rd(8'h68, 32'h0000_0008);
		$display("host mode and save done");
		inertia_stiffness <= 5'h07;
		inertia_done <= 1'b1;
		@(posedge mclk);
		inertia_done <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(stiffness_level, 5'h07);
		// Clock enable low must freeze the stiffness update
		ce <= 1'b0;
		inertia_stiffness <= 5'h03;
		inertia_done <= 1'b1;
		@(posedge mclk);
		inertia_done <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(stiffness_level, 5'h07);
		ce <= 1'b1;
		attached_valid <= 1'b1;
		attached_model <= 16'h0123;
		@(posedge mclk);
		attached_valid <= 1'b0;
		repeat (3) @(posedge mclk);
		rd(8'h44, 32'h0000_0123);
		// Browse to the gear numerator: 1000 shown as decimal digits
		repeat (60) @(posedge mclk);
		keypad_model_i.press(0);
		repeat (3) keypad_model_i.press(1);
		chk(disp_digits, 16'h1000);
		chk(disp_hex, 1'b0);
		attached_valid <= 1'b1;
		attached_model <= 16'h0456;
		@(posedge mclk);
		attached_valid <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(mismatch_fault, 1'b1);
		chk(disp_digits, 16'hffff);
		apb(1'b0, 8'hfc, 32'h0000_0000, v, e);
		chk(e, 1'b1);
		$display("stiffness, motor and bus done");
		end_of_test();
	end
endmodule : quick_setup_parameter_menu_bench
`default_nettype wire
